// ==== rtl/fomu_math_unit.sv ====
// Four operand math unit: sequencer, operand select, register port.
// Assumes en_i and src_values_i come from logic on clock_i.
`timescale 1ns/1ps
`include "fomu_map.svh"

// How it works
// - Always four operands and three operators, fixed in number.
// - Each function field picks add, subtract, multiply or divide.
// - Operations run in rank order high, medium, then low.
// - Result is rounded to the nearest integer.
// - Divide by zero or positive overflow gives 32767.
// - Negative overflow gives -32768.
// - Out-of-range block operands clamp to -32768 or 32767.
// - Block enables on a low-to-high change of its enable input.
// - Hold off and enable low forces the result to zero.
// - Hold on and enable low keeps the last result.
// - Error flags tell divide by zero from overflow, one reader.
// - Each operand is a constant or another block's value.
// - Decimal count only affects display, never arithmetic.
module fomu_math_unit
	import fomu_pkg::*;
#(
	parameter int NUM_SRC = 16,
	parameter int CYCLE_CLKS = `FOMU_CYCLE_CLKS
)
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire logic en_i,
	input wire logic [NUM_SRC-1:0][31:0] src_values_i,
	output logic signed [15:0] result_value_o,
	output fomu_err_t err_flags_o,
	output logic [1:0] decimal_count_o,
	output logic enabled_o
);
	// Refuse sizes the sequencer or block number field cannot serve
	initial
	begin
		if (NUM_SRC < 1 || NUM_SRC > 16)
			$error("NUM_SRC must be 1 to 16");
		if (CYCLE_CLKS < 8)
			$error("CYCLE_CLKS must be at least 8");
	end

	logic [31:0] ctrl_reg;
	logic [31:0] opnd_reg [4];
	logic [31:0] rdata_reg;
	logic en_prev_reg;
	logic enabled_reg;
	logic [15:0] tick_cnt_reg;
	logic tick_reg;
	fomu_state_t state_reg;
	logic [1:0] step_reg;
	logic signed [31:0] val_q [4];
	fomu_func_t op_q [3];
	fomu_rank_t rank_q [3];
	fomu_err_t acc_reg;
	logic signed [15:0] result_reg;
	fomu_err_t err_reg;
	logic rank_bad_reg;
	logic signed [31:0] raw_opnd [4];
	logic signed [15:0] opnd_val [4];
	logic [3:0] opnd_hi;
	logic [3:0] opnd_lo;
	logic [1:0] k_sel;
	logic k_found;
	logic signed [31:0] alu_res;
	fomu_err_t alu_err;
	logic signed [15:0] fin_val;
	logic fin_hi;
	logic fin_lo;
	logic hold_cfg;
	logic enable_rise;

	assign hold_cfg = ctrl_reg[`FOMU_CTRL_HOLD_BIT];
	assign enable_rise = en_i && !en_prev_reg;

	// Register writes; one word per address
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			ctrl_reg <= `FOMU_CTRL_RESET;
			for (int i = 0; i < 4; i++)
				opnd_reg[i] <= `FOMU_OPND_RESET;
		end
		else if (wr_i)
		begin
			case (addr_i)
				`FOMU_ADDR_CTRL: ctrl_reg <= {17'h0, wdata_i[14:0]};
				`FOMU_ADDR_OPND0: opnd_reg[0] <= wdata_i & 32'h00F1_FFFF;
				`FOMU_ADDR_OPND1: opnd_reg[1] <= wdata_i & 32'h00F1_FFFF;
				`FOMU_ADDR_OPND2: opnd_reg[2] <= wdata_i & 32'h00F1_FFFF;
				`FOMU_ADDR_OPND3: opnd_reg[3] <= wdata_i & 32'h00F1_FFFF;
				default: ;
			endcase
		end
	end

	// Read data stands in the cycle after the read strobe only
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			rdata_reg <= 32'h0;
		else if (!rd_i)
			rdata_reg <= 32'h0;
		else
		begin
			case (addr_i)
				`FOMU_ADDR_CTRL: rdata_reg <= ctrl_reg;
				`FOMU_ADDR_OPND0: rdata_reg <= opnd_reg[0];
				`FOMU_ADDR_OPND1: rdata_reg <= opnd_reg[1];
				`FOMU_ADDR_OPND2: rdata_reg <= opnd_reg[2];
				`FOMU_ADDR_OPND3: rdata_reg <= opnd_reg[3];
				`FOMU_ADDR_RESULT: rdata_reg <= {16'h0, result_reg};
				`FOMU_ADDR_STATUS: rdata_reg <= {26'h0, rank_bad_reg,
					state_reg != ST_IDLE, enabled_reg, err_reg.ovf_neg,
					err_reg.ovf_pos, err_reg.div_zero};
				default: rdata_reg <= 32'h0;
			endcase
		end
	end

	// Enable follows the edge, not the level: a high en_i at reset
	// counts as a rise on the first clock, as en_prev_reg resets to 0
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			en_prev_reg <= 1'b0;
			enabled_reg <= 1'b0;
		end
		else
		begin
			en_prev_reg <= en_i;
			if (!en_i)
				enabled_reg <= 1'b0;
			else if (enable_rise)
				enabled_reg <= 1'b1;
		end
	end

	// Program cycle divider; one-cycle tick
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			tick_cnt_reg <= 16'h0;
			tick_reg <= 1'b0;
		end
		else if (tick_cnt_reg == 16'(CYCLE_CLKS - 1))
		begin
			tick_cnt_reg <= 16'h0;
			tick_reg <= 1'b1;
		end
		else
		begin
			tick_cnt_reg <= tick_cnt_reg + 16'h1;
			tick_reg <= 1'b0;
		end
	end

	// Operand source: constant field or a block's live value
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			raw_opnd[i] = 32'(signed'(opnd_reg[i][15:0]));
			if (opnd_reg[i][`FOMU_OPND_USE_BIT])
			begin
				if (int'(opnd_reg[i][23:20]) < NUM_SRC)
					raw_opnd[i] = src_values_i[opnd_reg[i][23:20]];
				else
					raw_opnd[i] = 32'sh0; // Missing block reads zero
			end
		end
	end

	// Block values outside the 16-bit range are clamped
	for (genvar g = 0; g < 4; g++)
	begin : g_clamp
		fomu_sat16 u_clamp (
			.val_i(raw_opnd[g]),
			.val_o(opnd_val[g]),
			.hi_o(opnd_hi[g]),
			.lo_o(opnd_lo[g])
		);
	end

	// Pick the remaining operator whose rank matches this step;
	// a bad rank set falls back to the leftmost operator
	always_comb
	begin
		k_sel = 2'd0;
		k_found = 1'b0;
		for (int i = 2; i >= 0; i--)
		begin
			if (i < 3 - int'(step_reg) && rank_q[i] == fomu_rank_t'(step_reg))
			begin
				k_sel = 2'(i);
				k_found = 1'b1;
			end
		end
	end

	// Operator k joins the value on its left and on its right
	fomu_alu_op u_alu (
		.a_i(val_q[k_sel]),
		.b_i(val_q[2'(k_sel + 2'd1)]),
		.func_i(op_q[k_sel]),
		.res_o(alu_res),
		.err_o(alu_err)
	);

	fomu_sat16 u_final (
		.val_i(val_q[0]),
		.val_o(fin_val),
		.hi_o(fin_hi),
		.lo_o(fin_lo)
	);

	// Sequencer: load, three collapsing steps, then publish
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			state_reg <= ST_IDLE;
			step_reg <= 2'd0;
			acc_reg <= '0;
			rank_bad_reg <= 1'b0;
			for (int i = 0; i < 4; i++)
				val_q[i] <= 32'sh0;
			for (int i = 0; i < 3; i++)
			begin
				op_q[i] <= FOMU_ADD;
				rank_q[i] <= FOMU_HIGH;
			end
		end
		else if (!en_i)
			state_reg <= ST_IDLE; // Abort; a half result is never shown
		else
		begin
			case (state_reg)
				ST_IDLE:
					if (tick_reg && enabled_reg)
						state_reg <= ST_LOAD;
				ST_LOAD:
				begin
					// Decimal count is never read here: display only
					for (int i = 0; i < 4; i++)
						val_q[i] <= 32'(opnd_val[i]);
					for (int i = 0; i < 3; i++)
					begin
						op_q[i] <= fomu_func_t'(ctrl_reg[2*i +: 2]);
						rank_q[i] <= fomu_rank_t'(ctrl_reg[6+2*i +: 2]);
					end
					acc_reg <= '0;
					rank_bad_reg <= 1'b0;
					step_reg <= 2'd0;
					state_reg <= ST_EVAL;
				end
				ST_EVAL:
				begin
					// Collapse the pair into slot k and shift the rest left
					val_q[k_sel] <= alu_res;
					for (int i = 1; i < 3; i++)
						if (i > int'(k_sel))
							val_q[i] <= val_q[i+1];
					for (int i = 0; i < 2; i++)
						if (i >= int'(k_sel))
						begin
							op_q[i] <= op_q[i+1];
							rank_q[i] <= rank_q[i+1];
						end
					acc_reg <= acc_reg | alu_err;
					if (!k_found)
						rank_bad_reg <= 1'b1;
					step_reg <= step_reg + 2'd1;
					if (step_reg == 2'd2)
						state_reg <= ST_DONE;
				end
				ST_DONE:
					state_reg <= ST_IDLE;
				default:
					state_reg <= ST_IDLE;
			endcase
		end
	end

	// Result and error flags; disable behaviour takes priority
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
		begin
			result_reg <= 16'sh0;
			err_reg <= '0;
		end
		else if (!en_i)
		begin
			if (!hold_cfg)
				result_reg <= 16'sh0;
		end
		else if (state_reg == ST_DONE)
		begin
			// Integer ops plus rounded division give integer results
			if (acc_reg.div_zero || acc_reg.ovf_pos || fin_hi)
				result_reg <= `FOMU_SAT_MAX;
			else if (acc_reg.ovf_neg || fin_lo)
				result_reg <= `FOMU_SAT_MIN;
			else
				result_reg <= fin_val;
			err_reg.div_zero <= acc_reg.div_zero;
			err_reg.ovf_pos <= acc_reg.ovf_pos || fin_hi;
			err_reg.ovf_neg <= acc_reg.ovf_neg || fin_lo;
		end
	end

	assign rdata_o = rdata_reg;
	assign result_value_o = result_reg;
	assign err_flags_o = err_reg;
	assign decimal_count_o = ctrl_reg[14:13];
	assign enabled_o = enabled_reg;

	// Checks on the published behaviour
	sat_pos_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state_reg == ST_DONE && en_i && (acc_reg.div_zero || acc_reg.ovf_pos))
		|=> result_reg == `FOMU_SAT_MAX)
		else $error("positive saturation missed");
	sat_neg_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state_reg == ST_DONE && en_i && !acc_reg.div_zero && !acc_reg.ovf_pos
		&& !fin_hi && acc_reg.ovf_neg) |=> result_reg == `FOMU_SAT_MIN)
		else $error("negative saturation missed");
	off_zero_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(!en_i && !hold_cfg) |=> result_reg == 16'sh0)
		else $error("result not cleared while disabled");
	off_hold_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(!en_i && hold_cfg) |=> $stable(result_reg))
		else $error("result changed while held");
	enable_edge_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(!enabled_reg && !enable_rise) |=> !enabled_reg)
		else $error("enabled without a rising edge");
	eval_span_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state_reg == ST_LOAD && en_i) ##1 en_i [*3] |=> state_reg == ST_DONE)
		else $error("evaluation did not finish in four cycles");
	idle_tick_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state_reg == ST_IDLE && !tick_reg) |=> state_reg == ST_IDLE)
		else $error("evaluation started without a cycle tick");
	opnd_clamp_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(raw_opnd[0] > 32'sh0000_7FFF |-> opnd_val[0] == `FOMU_SAT_MAX)
		and (raw_opnd[0] < 32'shFFFF_8000 |-> opnd_val[0] == `FOMU_SAT_MIN))
		else $error("operand not clamped");
	rank_order_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state_reg == ST_EVAL && k_found) |-> rank_q[k_sel] == fomu_rank_t'(step_reg))
		else $error("operation taken out of rank order");
	div_flag_a: assert property (@(posedge clock_i) disable iff (!reset_n_i)
		(state_reg == ST_EVAL && en_i && alu_err.div_zero) |=> acc_reg.div_zero)
		else $error("divide by zero not flagged");
endmodule // fomu_math_unit

// ==== rtl/fomu_map.svh ====
// Register offsets, field positions, reset values and timing counts
// for the four operand math unit. Definitions only; include by name.
`ifndef FOMU_MAP_SVH
`define FOMU_MAP_SVH

// Word-aligned byte offsets on the plain register port
`define FOMU_ADDR_CTRL 8'h00
`define FOMU_ADDR_OPND0 8'h04
`define FOMU_ADDR_OPND1 8'h08
`define FOMU_ADDR_OPND2 8'h0C
`define FOMU_ADDR_OPND3 8'h10
`define FOMU_ADDR_RESULT 8'h14
`define FOMU_ADDR_STATUS 8'h18

// Control register fields (two bits per function and per rank)
`define FOMU_CTRL_FUNC_LSB 0
`define FOMU_CTRL_RANK_LSB 6
`define FOMU_CTRL_HOLD_BIT 12
`define FOMU_CTRL_DEC_LSB 13
`define FOMU_CTRL_RESET 32'h0000_0900

// Operand register fields
`define FOMU_OPND_USE_BIT 16
`define FOMU_OPND_BLK_LSB 20
`define FOMU_OPND_RESET 32'h0000_0000

// Status register bits
`define FOMU_STAT_DIV0 0
`define FOMU_STAT_OVFP 1
`define FOMU_STAT_OVFN 2
`define FOMU_STAT_EN 3
`define FOMU_STAT_BUSY 4
`define FOMU_STAT_RANKBAD 5

// Saturation limits of result and operands
`define FOMU_SAT_MAX 16'h7FFF
`define FOMU_SAT_MIN 16'h8000

// Program evaluation cycle
`define FOMU_CLK_NS 50
`define FOMU_CYCLE_NS 1000
`define FOMU_CYCLE_CLKS (`FOMU_CYCLE_NS / `FOMU_CLK_NS)

`endif

// ==== rtl/fomu_pkg.sv ====
// Types shared by the four operand math unit files.
// Assumes fomu_map.svh supplies all numeric constants.
package fomu_pkg;
	typedef enum logic [1:0] {FOMU_ADD, FOMU_SUB, FOMU_MUL, FOMU_DIV}
		fomu_func_t;
	typedef enum logic [1:0] {FOMU_HIGH, FOMU_MED, FOMU_LOW, FOMU_BAD}
		fomu_rank_t;
	typedef enum {ST_IDLE, ST_LOAD, ST_EVAL, ST_DONE} fomu_state_t;
	typedef struct packed {
		logic div_zero;
		logic ovf_pos;
		logic ovf_neg;
	} fomu_err_t;
endpackage

// ==== rtl/fomu_sat16.sv ====
// Saturates a 32-bit signed value into the 16-bit operand/result range.
// Purely combinational; the caller registers the outcome.
`timescale 1ns/1ps
`include "fomu_map.svh"
module fomu_sat16
(
	input wire logic signed [31:0] val_i,
	output logic signed [15:0] val_o,
	output logic hi_o,
	output logic lo_o
);
	// Compare against the limits widened to 32 bits
	always_comb
	begin
		hi_o = val_i > 32'(signed'(`FOMU_SAT_MAX));
		lo_o = val_i < 32'(signed'(`FOMU_SAT_MIN));
		if (hi_o)
			val_o = `FOMU_SAT_MAX;
		else if (lo_o)
			val_o = `FOMU_SAT_MIN;
		else
			val_o = val_i[15:0];
	end
endmodule // fomu_sat16

// ==== rtl/fomu_alu_op.sv ====
// One arithmetic operation on two 32-bit intermediates.
// Combinational; the sequencer in the top module holds the operands.
`timescale 1ns/1ps
module fomu_alu_op
	import fomu_pkg::*;
(
	input wire logic signed [31:0] a_i,
	input wire logic signed [31:0] b_i,
	input wire fomu_func_t func_i,
	output logic signed [31:0] res_o,
	output fomu_err_t err_o
);
	logic signed [63:0] wa;
	logic signed [63:0] wb;
	logic signed [63:0] wide;
	logic [63:0] mag_a;
	logic [63:0] mag_b;
	logic [63:0] quo;

	// Wide math so no intermediate wraps before overflow is judged
	always_comb
	begin
		wa = 64'(a_i);
		wb = 64'(b_i);
		mag_a = wa[63] ? 64'(-wa) : 64'(wa);
		mag_b = wb[63] ? 64'(-wb) : 64'(wb);
		// Half away from zero: add half the divisor before dividing
		quo = (mag_b == 64'h0) ? 64'h0 : (mag_a + (mag_b >> 1)) / mag_b;
		err_o = '0;
		case (func_i)
			FOMU_ADD: wide = wa + wb;
			FOMU_SUB: wide = wa - wb;
			FOMU_MUL: wide = wa * wb;
			FOMU_DIV:
			begin
				wide = (wa[63] ^ wb[63]) ? -$signed(quo) : $signed(quo);
				err_o.div_zero = (wb == 64'sh0);
			end
			default: wide = 64'sh0;
		endcase
		err_o.ovf_pos = wide > 64'sh0000_0000_7FFF_FFFF;
		err_o.ovf_neg = wide < 64'shFFFF_FFFF_8000_0000;
		res_o = wide[31:0];
	end
endmodule // fomu_alu_op

// ==== test/fomu_src_model.sv ====
// Model of the other function blocks that supply operand values.
// Assumes the bench loads one block value per set_i pulse.
`timescale 1ns/1ps
module fomu_src_model
#(
	parameter int NUM_SRC = 16
)
(
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic set_i,
	input wire logic [3:0] idx_i,
	input wire logic [31:0] val_i,
	output logic [NUM_SRC-1:0][31:0] src_values_o
);
	// Values move only on the clock, as real blocks' outputs do
	always_ff @(posedge clock_i or negedge reset_n_i)
	begin
		if (!reset_n_i)
			src_values_o <= '0;
		else if (set_i)
			src_values_o[idx_i] <= val_i;
	end
endmodule // fomu_src_model

// ==== test/fomu_math_unit_bench.sv ====
// Bench for the math unit: integer model against design results.
// Assumes fomu_pkg, fomu_map.svh and fomu_src_model are compiled.
`timescale 1ns/1ps
`include "fomu_map.svh"
`define CHK(n, e, g) \
	begin \
		comparisons++; \
		if ((g) !== (e)) \
		begin \
			error_cnt++; \
			$display("Error %s expected %0h seen %0h", n, e, g); \
		end \
	end
module fomu_math_unit_bench
	import fomu_pkg::*;
;
	logic clock_i, reset_n_i, wr, rd, en, set;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, sval, d;
	logic [3:0] sidx;
	logic [15:0][31:0] srcs;
	logic signed [15:0] res;
	fomu_err_t errf;
	logic [1:0] dec_o;
	logic enab;
	int error_cnt, comparisons, n, i, hold, dcnt;
	int v[4], f[3], r[3], blk[4];
	// Rank orders are always distinct permutations
	int pm[6][3] = '{'{0,1,2}, '{0,2,1}, '{1,0,2}, '{1,2,0}, '{2,0,1},
		'{2,1,0}};
	// Rounding, saturation and zero-divide cases padded with +0
	int sv[5][4] = '{'{7,2,0,0}, '{-7,2,0,0}, '{30000,30000,0,0},
		'{-30000,30000,0,0}, '{5,0,0,0}};
	int sf[5] = '{3, 3, 0, 1, 3};

	fomu_src_model #(.NUM_SRC(16)) i_fomu_src_model (.clock_i(clock_i),
		.reset_n_i(reset_n_i), .set_i(set), .idx_i(sidx), .val_i(sval),
		.src_values_o(srcs));
	fomu_math_unit #(.NUM_SRC(16), .CYCLE_CLKS(8)) i_fomu_math_unit (
		.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .en_i(en),
		.src_values_i(srcs), .result_value_o(res), .err_flags_o(errf),
		.decimal_count_o(dec_o), .enabled_o(enab));

	// 20 MHz clock
	initial
	begin
		clock_i = 1'b0;
		forever #25 clock_i = ~clock_i;
	end

	function automatic int iabs(input int x);
		return x < 0 ? -x : x;
	endfunction

	// Rank-ordered evaluation; merges the two values beside each operator
	function automatic int model(output logic [2:0] fl);
		int q[$];
		int o[$];
		int p[$];
		int j, k, a, b, x;
		bit dz;
		q = {v[0], v[1], v[2], v[3]};
		o = {f[0], f[1], f[2]};
		p = {r[0], r[1], r[2]};
		dz = 1'b0;
		for (k = 0; k < 3; k++)
		begin
			j = 0;
			while (p[j] != k)
				j++;
			a = q[j];
			b = q[j + 1];
			case (o[j])
				0: x = a + b;
				1: x = a - b;
				2: x = a * b;
				default:
				begin
					// Half away from zero, sign fixed afterwards
					dz |= (b == 0);
					x = (b == 0) ? 0 : (iabs(a) * 2 + iabs(b)) / (iabs(b) * 2);
					if ((a < 0) != (b < 0))
						x = -x;
				end
			endcase
			q[j] = x;
			q.delete(j + 1);
			o.delete(j);
			p.delete(j);
		end
		fl = {dz, !dz && q[0] > 32767, !dz && q[0] < -32768};
		return (dz || q[0] > 32767) ? 32767 : (q[0] < -32768 ? -32768 : q[0]);
	endfunction

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] w);
		@(posedge clock_i);
		addr <= a;
		wdata <= w;
		wr <= 1'b1;
		@(posedge clock_i);
		wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] q);
		@(posedge clock_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock_i);
		rd <= 1'b0;
		#1 q = rdata;
	endtask

	task automatic set_src(input logic [3:0] k, input logic [31:0] x);
		@(posedge clock_i);
		set <= 1'b1;
		sidx <= k;
		sval <= x;
		@(posedge clock_i);
		set <= 1'b0;
	endtask

	task automatic cfg();
		int k;
		wr_reg(`FOMU_ADDR_CTRL, 32'(f[0] | f[1] << 2 | f[2] << 4 | r[0] << 6
			| r[1] << 8 | r[2] << 10 | hold << 12 | dcnt << 13));
		for (k = 0; k < 4; k++)
			wr_reg(8'(`FOMU_ADDR_OPND0 + 4 * k), blk[k] < 0 ?
				{16'h0000, 16'(v[k])} : {8'h00, 4'(blk[k]), 4'h1, 16'h0000});
	endtask

	// Three program cycles guarantee one whole evaluation after setup
	task automatic settle_check();
		logic [2:0] fl;
		int e;
		repeat (24) @(posedge clock_i);
		e = model(fl);
		#1;
		`CHK("result", 16'(e), res)
		`CHK("flags", fl, errf)
		`CHK("decimals", 2'(dcnt), dec_o)
		rd_reg(`FOMU_ADDR_RESULT, d);
		`CHK("result reg", {16'h0000, 16'(e)}, d)
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d errors %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	// Watchdog sized well above the expected run of a few thousand cycles
	initial
	begin
		repeat (20000) @(posedge clock_i);
		error_cnt++;
		report_and_stop();
	end

	// Main sequence
	initial
	begin
		error_cnt = 0;
		comparisons = 0;
		reset_n_i = 1'b0;
		{wr, rd, en, set} = 4'h0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		sidx = 4'h0;
		sval = 32'h0000_0000;
		hold = 0;
		dcnt = 0;
		blk = '{-1, -1, -1, -1};
		void'($urandom(65));
		repeat (6) @(posedge clock_i);
		reset_n_i <= 1'b1;
		rd_reg(`FOMU_ADDR_CTRL, d);
		`CHK("ctrl reset", `FOMU_CTRL_RESET, d)
		rd_reg(8'h1C, d);
		`CHK("unmapped", 32'h0000_0000, d)
		v = '{12, 6, 3, 1};
		f = '{0, 3, 1};
		r = '{1, 0, 2};
		cfg();
		repeat (24) @(posedge clock_i);
		#1 `CHK("no edge yet", 16'h0000, res)
		@(posedge clock_i);
		en <= 1'b1;
		settle_check();
		`CHK("enabled", 1'b1, enab)
		v = '{2, 3, 1, 4};
		f = '{0, 2, 0};
		r = '{2, 1, 0};
		cfg();
		settle_check();
		for (n = 0; n < 5; n++)
		begin
			v = sv[n];
			f = '{sf[n], 0, 0};
			r = '{0, 1, 2};
			cfg();
			settle_check();
		end
		// Random operands small enough that only the model's rules matter
		for (n = 0; n < 48; n++)
		begin
			r = pm[n % 6];
			for (i = 0; i < 4; i++)
				v[i] = int'($urandom_range(24)) - 12;
			for (i = 0; i < 3; i++)
				f[i] = int'($urandom_range(3));
			dcnt = int'($urandom_range(3));
			cfg();
			settle_check();
		end
		// Block-sourced operands, clamped when out of range
		set_src(4'h3, 32'h0000_9C40);
		set_src(4'h5, 32'hFFFF_63C0);
		set_src(4'h7, 32'h0000_0064);
		v = '{32767, 0, 1, 0};
		f = '{0, 2, 0};
		r = '{0, 1, 2};
		blk[0] = 3;
		cfg();
		settle_check();
		blk[0] = 5;
		v[0] = -32768;
		cfg();
		settle_check();
		blk[0] = 7;
		v[0] = 100;
		cfg();
		settle_check();
		set_src(4'h7, 32'h0000_00C8);
		v[0] = 200;
		settle_check();
		@(posedge clock_i);
		en <= 1'b0;
		repeat (2) @(posedge clock_i);
		#1 `CHK("cleared", 16'h0000, res)
		hold = 1;
		@(posedge clock_i);
		en <= 1'b1;
		cfg();
		settle_check();
		@(posedge clock_i);
		en <= 1'b0;
		set_src(4'h7, 32'h0000_012C);
		repeat (24) @(posedge clock_i);
		#1 `CHK("held", 16'h00C8, res)
		`CHK("disabled", 1'b0, enab)
		report_and_stop();
	end
endmodule // fomu_math_unit_bench
